// file: rtl/aie_execute.sv
/*
 * Execution datapath for the immediate add and the file add, with the
 * accumulator, the file registers and the three arithmetic flags.
 * Assumes one instruction word is presented, held stable, while the
 * phase counter is in the first phase; other words execute as no-ops.
 */
`timescale 1ns/1ps
`include "aie_consts.svh"

module aie_execute
(
    input  wire logic        sys_clk,         // Core clock.
    input  wire logic        rst,             // Synchronous reset.
    input  wire logic [13:0] instr,           // Instruction word.
    output logic      [1:0]  phase,           // Current phase, 0 to 3.
    output logic      [7:0]  accumulator,     // Accumulator contents.
    output logic             carry_flag,      // Carry flag.
    output logic             half_carry_flag, // Half-carry flag.
    output logic             zero_flag,       // Zero flag.
    input  wire logic [6:0]  peek_addr,       // File register to observe.
    output logic      [7:0]  peek_data        // Observed file register.
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    ////////////////////////////////////////////////////////////////////////

    aie_pkg::aie_phase_t state;       // Current phase.
    aie_pkg::aie_phase_t next_state;  // Next phase.
    aie_pkg::aie_op_t    op;          // Decoded instruction kind.
    aie_pkg::aie_op_t    next_op;     // Next decoded kind.
    logic [7:0]          operand;     // Fetched second operand.
    logic [7:0]          next_operand;
    logic                dest;        // Destination bit latched.
    logic                next_dest;
    logic [6:0]          addr;        // File address latched.
    logic [6:0]          next_addr;
    logic [7:0]          result;      // Computed sum.
    logic [7:0]          next_result;
    logic [2:0]          flags;       // Carry, half-carry, zero computed.
    logic [2:0]          next_flags;
    logic [7:0]          acc;         // Accumulator register.
    logic [7:0]          next_acc;
    logic [2:0]          sflags;      // Architectural flags.
    logic [2:0]          next_sflags;
    logic [7:0]          file_mem [`AIE_FILE_DEPTH]; // File registers.
    logic [7:0]          lit;         // Literal field.
    logic                file_we;     // File write strobe in fourth phase.
    logic [7:0]          add_sum;     // Adder sum.
    logic                add_c;       // Adder carry.
    logic                add_dc;      // Adder half-carry.
    logic                add_z;       // Adder zero.

    // Decode an instruction word into its kind.
    function automatic aie_pkg::aie_op_t aie_decode(input logic [13:0] w);
        if (w[`AIE_IMM_TOP_HI:`AIE_IMM_TOP_LO] == `AIE_IMM_TOP_VAL)
            return aie_pkg::AIE_OP_IMM;
        else if (w[`AIE_FILE_TOP_HI:`AIE_FILE_TOP_LO] == `AIE_FILE_TOP_VAL)
            return aie_pkg::AIE_OP_FILE;
        else
            return aie_pkg::AIE_OP_NONE;
    endfunction : aie_decode

    assign lit = instr[`AIE_LIT_HI:0];

    ////////////////////////////////////////////////////////////////////////
    // Adder.
    ////////////////////////////////////////////////////////////////////////

    // The adder always sums the accumulator with the fetched operand.
    aie_adder u_adder
    (
        .op_a       (acc),
        .op_b       (operand),
        .sum        (add_sum),
        .carry      (add_c),
        .half_carry (add_dc),
        .zero       (add_z)
    );

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencing and datapath next values.
    ////////////////////////////////////////////////////////////////////////

    // Walk the four phases and stage the datapath.
    always_comb
    begin
        next_state   = state;
        next_op      = op;
        next_operand = operand;
        next_dest    = dest;
        next_addr    = addr;
        next_result  = result;
        next_flags   = flags;
        next_acc     = acc;
        next_sflags  = sflags;
        file_we      = 1'b0;
        unique case (state)
            aie_pkg::AIE_Q1:
            begin
                // Decode and latch the fields.
                next_state = aie_pkg::AIE_Q2;
                next_op    = aie_decode(instr);
                next_dest  = instr[`AIE_DEST_BIT];
                next_addr  = instr[`AIE_ADDR_HI:0];
                next_operand = lit;
            end
            aie_pkg::AIE_Q2:
            begin
                // Read the file register for a file add; the literal was latched in Q1.
                next_state = aie_pkg::AIE_Q3;
                if (op == aie_pkg::AIE_OP_FILE)
                    next_operand = file_mem[addr];
            end
            aie_pkg::AIE_Q3:
            begin
                // Compute the sum and flags.
                next_state  = aie_pkg::AIE_Q4;
                next_result = add_sum;
                next_flags  = {add_c, add_dc, add_z};
            end
            aie_pkg::AIE_Q4:
            begin
                // Write the destination and the three flags.
                next_state = aie_pkg::AIE_Q1;
                if (op != aie_pkg::AIE_OP_NONE)
                    next_sflags = flags;
                if (op == aie_pkg::AIE_OP_IMM)
                    next_acc = result;
                else if (op == aie_pkg::AIE_OP_FILE && !dest)
                    next_acc = result;
                else if (op == aie_pkg::AIE_OP_FILE)
                    file_we = 1'b1;
            end
        endcase
    end

    // Register the phase and datapath state.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state   <= aie_pkg::AIE_Q1;
            op      <= aie_pkg::AIE_OP_NONE;
            operand <= `AIE_ACC_RESET;
            dest    <= `AIE_FLAG_RESET;
            addr    <= `AIE_ADDR_RESET;
            result  <= `AIE_ACC_RESET;
            flags   <= `AIE_SFLAGS_RESET;
            acc     <= `AIE_ACC_RESET;
            sflags  <= `AIE_SFLAGS_RESET;
        end
        else
        begin
            state   <= next_state;
            op      <= next_op;
            operand <= next_operand;
            dest    <= next_dest;
            addr    <= next_addr;
            result  <= next_result;
            flags   <= next_flags;
            acc     <= next_acc;
            sflags  <= next_sflags;
        end
    end

    // File registers clear on reset, so that no add ever reads an
    // unknown operand and every destination can be observed.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `AIE_FILE_DEPTH; i++)
                file_mem[i] <= `AIE_FILE_RESET;
        end
        else if (file_we)
            file_mem[addr] <= result;
    end

    // Observation port for the file registers, registered.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            peek_data <= `AIE_FILE_RESET;
        else
            peek_data <= file_mem[peek_addr];
    end

    assign phase           = state;
    assign accumulator     = acc;
    assign carry_flag      = sflags[`AIE_FLAG_C];
    assign half_carry_flag = sflags[`AIE_FLAG_DC];
    assign zero_flag       = sflags[`AIE_FLAG_Z];

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////

    chk_imm_acc_write: assert property (@(posedge sys_clk) disable iff (rst)
        (state == aie_pkg::AIE_Q4 && op == aie_pkg::AIE_OP_IMM)
        |=> acc == $past(result))
        else $error("Immediate add did not write the accumulator.");

    chk_imm_decode: assert property (@(posedge sys_clk) disable iff (rst)
        (state == aie_pkg::AIE_Q1 &&
         instr[`AIE_IMM_TOP_HI:`AIE_IMM_TOP_LO] == `AIE_IMM_TOP_VAL)
        |=> op == aie_pkg::AIE_OP_IMM)
        else $error("Immediate add not decoded.");

    chk_phase_walk: assert property (@(posedge sys_clk) disable iff (rst)
        state == aie_pkg::AIE_Q1 |=> state == aie_pkg::AIE_Q2 ##1
        state == aie_pkg::AIE_Q3 ##1 state == aie_pkg::AIE_Q4 ##1
        state == aie_pkg::AIE_Q1)
        else $error("Phase sequence broken.");

    chk_file_sum: assert property (@(posedge sys_clk) disable iff (rst)
        (state == aie_pkg::AIE_Q3 && op == aie_pkg::AIE_OP_FILE)
        |=> result == $past(acc) + $past(operand))
        else $error("File add sum wrong.");

    chk_dest_acc: assert property (@(posedge sys_clk) disable iff (rst)
        (state == aie_pkg::AIE_Q4 && op == aie_pkg::AIE_OP_FILE && !dest)
        |-> !file_we ##1 acc == $past(result))
        else $error("Accumulator destination mishandled.");

    chk_dest_file: assert property (@(posedge sys_clk) disable iff (rst)
        (state == aie_pkg::AIE_Q4 && op == aie_pkg::AIE_OP_FILE && dest)
        |-> file_we ##1 $stable(acc))
        else $error("File destination mishandled.");

    chk_file_decode: assert property (@(posedge sys_clk) disable iff (rst)
        (state == aie_pkg::AIE_Q1 &&
         instr[`AIE_FILE_TOP_HI:`AIE_FILE_TOP_LO] == `AIE_FILE_TOP_VAL)
        |=> op == aie_pkg::AIE_OP_FILE &&
        addr == $past(instr[`AIE_ADDR_HI:0]))
        else $error("File add not decoded.");

    chk_file_write_phase: assert property (@(posedge sys_clk)
        disable iff (rst)
        file_we |-> state == aie_pkg::AIE_Q4)
        else $error("File write outside fourth phase.");

    chk_flags_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (state != aie_pkg::AIE_Q4 || op == aie_pkg::AIE_OP_NONE)
        |=> $stable(sflags))
        else $error("Flags changed without an add.");

    chk_flag_zero: assert property (@(posedge sys_clk) disable iff (rst)
        state == aie_pkg::AIE_Q3 |=> flags[`AIE_FLAG_Z] ==
        (($past(acc) + $past(operand)) == 8'h00))
        else $error("Zero flag wrong.");

    chk_flag_carry: assert property (@(posedge sys_clk) disable iff (rst)
        state == aie_pkg::AIE_Q3 |=> flags[`AIE_FLAG_C] ==
        (({1'b0, $past(acc)} + {1'b0, $past(operand)}) > 9'h0ff))
        else $error("Carry flag wrong.");

endmodule : aie_execute

// file: inc/aie_consts.svh
/*
 * Constants of the add-instruction execution datapath: opcode fields,
 * file depth, reset values and flag positions.
 * Assumes it is included by bare name by the design files.
 */
`ifndef AIE_CONSTS_SVH
`define AIE_CONSTS_SVH

// Field positions within the 14-bit instruction word.
`define AIE_IMM_TOP_HI   13
`define AIE_IMM_TOP_LO   9
`define AIE_IMM_TOP_VAL  5'h1f
`define AIE_FILE_TOP_HI  13
`define AIE_FILE_TOP_LO  8
`define AIE_FILE_TOP_VAL 6'h07
`define AIE_DEST_BIT     7
`define AIE_ADDR_HI      6
`define AIE_LIT_HI       7

// Number of file registers the datapath may address.
`define AIE_FILE_DEPTH   128

// Reset values.
`define AIE_ACC_RESET    8'h00
`define AIE_FLAG_RESET   1'b0
`define AIE_ADDR_RESET   7'h00
`define AIE_SFLAGS_RESET 3'h0
`define AIE_FILE_RESET   8'h00

// Bit positions of the flags inside the three-bit flag groups.
`define AIE_FLAG_C       2
`define AIE_FLAG_DC      1
`define AIE_FLAG_Z       0

`endif

// file: inc/aie_pkg.sv
/*
 * Types of the add-instruction execution datapath.
 * Assumes the constants header sits beside it on the include path.
 */
package aie_pkg;

    // Phases of one instruction cycle.
    typedef enum logic [1:0] {
        AIE_Q1,
        AIE_Q2,
        AIE_Q3,
        AIE_Q4
    } aie_phase_t;

    // Kind of instruction held for the current cycle.
    typedef enum logic [1:0] {
        AIE_OP_NONE,
        AIE_OP_IMM,
        AIE_OP_FILE
    } aie_op_t;

endpackage : aie_pkg

// file: rtl/aie_adder.sv
/*
 * Eight-bit adder with carry, half-carry and zero outputs.
 * Assumes purely combinational use inside the execution datapath.
 */
`timescale 1ns/1ps
`include "aie_consts.svh"

module aie_adder
(
    input  wire logic [7:0] op_a,       // First addend.
    input  wire logic [7:0] op_b,       // Second addend.
    output logic      [7:0] sum,        // Eight-bit sum.
    output logic            carry,      // Carry out of bit 7.
    output logic            half_carry, // Carry out of bit 3.
    output logic            zero        // Sum equals zero.
);

    // Wide intermediate results so the carries can be read directly.
    logic [8:0] full_sum;   // Nine-bit sum.
    logic [4:0] nibble_sum; // Five-bit low-nibble sum.

    // Add the operands and derive the flags.
    always_comb
    begin
        full_sum   = {1'b0, op_a} + {1'b0, op_b};
        nibble_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
        sum        = full_sum[7:0];
        carry      = full_sum[8];
        half_carry = nibble_sum[4];
        zero       = (full_sum[7:0] == 8'h00);
    end

endmodule : aie_adder

// file: bench/tb_top.sv
/*
 * Self-checking testbench of the add-instruction execution datapath.
 * Assumes the constants header and package are compiled first, and that
 * reset clears the file registers, so every add works on known values.
 */
`timescale 1ns/1ps

module tb_top;

    ////////////////////////////////////////////////////////////////////////
    // Signals, model state and counters.
    logic        sys_clk;          // Core clock, 200 MHz.
    logic        rst;              // Synchronous reset, active high.
    logic [13:0] instr;            // Instruction word driven to the core.
    logic [6:0]  peek_addr;        // File register being observed.
    logic [1:0]  phase;            // Phase seen from the core.
    logic [7:0]  accumulator;      // Accumulator seen from the core.
    logic        carry_flag;       // Carry seen from the core.
    logic        half_carry_flag;  // Half-carry seen from the core.
    logic        zero_flag;        // Zero seen from the core.
    logic [7:0]  peek_data;        // File register seen from the core.
    int          err_total;        // Mismatches counted.
    int          checks_done;      // Comparisons made.
    logic [31:0] seed;             // Random state.
    logic [7:0]  m_acc;            // Expected accumulator.
    logic        m_c;              // Expected carry.
    logic        m_dc;             // Expected half-carry.
    logic        m_z;              // Expected zero.
    logic [7:0]  m_mem [128];      // Expected file registers.
    logic [7:0]  m_peek;           // Expected observed file register.
    logic [13:0] corner [18];      // Hand-written corner words.

    aie_execute DUT
    (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .instr           (instr),
        .phase           (phase),
        .accumulator     (accumulator),
        .carry_flag      (carry_flag),
        .half_carry_flag (half_carry_flag),
        .zero_flag       (zero_flag),
        .peek_addr       (peek_addr),
        .peek_data       (peek_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock generation.
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper functions and tasks.

    // Xorshift step giving the next random state.
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : next_rand

    // Compares one value with its expectation and reports a mismatch.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Prints the verdict and ends the run.
    task automatic conclude;
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // Applies one word to the expected state; unknown operands stay unknown.
    task automatic model(input logic [13:0] w);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        logic       is_imm;
        logic       is_file;
        is_imm  = (w[13:9] == 5'h1f);
        is_file = (w[13:8] == 6'h07);
        b       = is_imm ? w[7:0] : m_mem[w[6:0]];
        m_peek  = m_mem[w[6:0]];
        if (is_imm || is_file)
        begin
            s    = {1'b0, m_acc} + {1'b0, b};
            h    = {1'b0, m_acc[3:0]} + {1'b0, b[3:0]};
            m_c  = s[8];
            m_dc = h[4];
            m_z  = (s[7:0] == 8'h00);
            // A set destination bit sends the sum back to the register.
            if (is_file && w[7])
                m_mem[w[6:0]] = s[7:0];
            else
                m_acc = s[7:0];
        end
    endtask : model

    // Issues one word at the edge leaving phase 3, then checks the accumulator
    // and flags of the previous word, which land at that same edge.
    task automatic exec(input logic [13:0] w);
        int n;
        n = 0;
        @(posedge sys_clk);
        while (phase !== 2'h3 && n < 16)
        begin
            n++;
            @(posedge sys_clk);
        end
        if (n >= 16)
        begin
            err_total++;
            conclude();
        end
        instr     <= w;
        peek_addr <= w[6:0];
        #1;
        check({3'h0, phase, accumulator, carry_flag, half_carry_flag,
               zero_flag}, {3'h0, 2'h0, m_acc, m_c, m_dc, m_z});
        check({8'h00, peek_data}, {8'h00, m_peek});
        model(w);
    endtask : exec

    // Holds reset for 16 cycles with a word that is no add on the bus.
    task automatic do_reset;
        @(posedge sys_clk);
        rst   <= 1'b1;
        instr <= 14'h0000;
        repeat (16) @(posedge sys_clk);
        rst   <= 1'b0;
        m_acc  = 8'h00;
        m_c    = 1'b0;
        m_dc   = 1'b0;
        m_z    = 1'b0;
        m_peek = 8'h00;
        foreach (m_mem[i])
            m_mem[i] = 8'h00;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need about a tenth of this span.
    initial
    begin
        repeat (32'h0000_2710) @(posedge sys_clk);
        err_total++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: corners, random words, then a reset mid-run.
    initial
    begin
        rst         = 1'b1;
        instr       = 14'h0000;
        peek_addr   = 7'h00;
        err_total   = 0;
        checks_done = 0;
        seed        = 32'h0000_e986;
        // Sums of 25, FF, wrap to zero, half-carry, near-miss no-ops, then
        // file adds to both destinations at both ends of the address range.
        corner = '{14'h3e10, 14'h3e15, 14'h3fda, 14'h3e01, 14'h3e0f,
                   14'h3e01, 14'h3e00, 14'h3c00, 14'h1e00, 14'h0c80,
                   14'h0e80, 14'h3eff, 14'h0780, 14'h07ff, 14'h0700,
                   14'h077f, 14'h0680, 14'h0f80};
        do_reset();
        foreach (corner[i])
            exec(corner[i]);
        // Random words: half immediate adds, a quarter file adds on eight
        // registers with either destination, the rest raw words.
        for (int k = 0; k < 200; k++)
        begin
            logic [13:0] w;
            seed = next_rand(seed);
            w    = seed[13:0];
            if (!seed[17])
                w = {5'h1f, seed[20], seed[31:24]};
            else if (!seed[16])
                w = {6'h07, seed[21], 4'h0, seed[26:24]};
            exec(w);
        end
        // A file add into the accumulator; reset must then clear the
        // accumulator, the flags and the file registers.
        exec(14'h077f);
        exec(14'h0000);
        do_reset();
        exec(14'h077f);
        exec(14'h3e42);
        exec(14'h3ebe);
        exec(14'h0000);
        conclude();
    end

endmodule : tb_top
